// ===== dv/csp_core_model.sv
// Purpose: Processor core side of the register bus
// Assumes: One access at a time, driven at falling edge
// Notes: Idle address shows an inverted pattern
`timescale 1ns/1ps
`default_nettype none
module csp_core_model (
    input wire logic clk,
    output logic [7:0] sfr_addr,
    output logic sfr_wr,
    output logic sfr_rd,
    output logic [7:0] sfr_wdata,
    output logic bit_set,
    output logic bit_clr,
    output logic [2:0] bit_pos,
    input wire logic [7:0] sfr_rdata
);
    initial begin
        {sfr_addr, sfr_wdata, bit_pos} = 19'h0;
        {sfr_wr, sfr_rd, bit_set, bit_clr} = 4'h0;
    end
    // Callers also address unoccupied places such as 91H
    task automatic op(input logic [7:0] a, d, input logic [3:0] st, input logic [2:0] p);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        bit_pos = p;
        {sfr_wr, sfr_rd, bit_set, bit_clr} = st;
        @(negedge clk);
        {sfr_wr, sfr_rd, bit_set, bit_clr} = 4'h0;
        sfr_addr = ~a;
        sfr_wdata = ~d;
    endtask
    // Read data stands one cycle, taken right after the answer edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        op(a, 8'h00, 4'h4, 3'h0);
        d = sfr_rdata;
    endtask
endmodule
`default_nettype wire

// ===== dv/csp_sfr_bank_assertions.sv
// Purpose: Port checks for the register bank
// Assumes: One clock, async active-high reset
// Notes: Bound from the bench top
`timescale 1ns/1ps
`default_nettype none
module csp_sfr_bank_assertions
    import csp_pkg::*;
#(
    parameter logic [7:0] SILICON_REV = 8'h5a
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic bit_set,
    input wire logic bit_clr,
    input wire logic [2:0] bit_pos,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_rvalid,
    input wire logic [7:0] acc_value,
    input wire csp_cal_t cal_factory,
    input wire csp_cal_t cal_coeff,
    input wire csp_flags_t flags,
    input wire csp_power_t power,
    input wire logic spi_master_sel,
    input wire logic spi_rate_bit0
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_rd(a);
        sfr_rd && sfr_addr == a;
    endsequence
    sequence s_wr(a);
        sfr_wr && sfr_addr == a;
    endsequence
    property p_rvalid; sfr_rd |=> sfr_rvalid; endproperty
    property p_rev; s_rd(ADDR_SILICON_REV) |=> sfr_rdata == SILICON_REV; endproperty
    property p_unmap; s_rd(8'h91) |=> sfr_rdata == 8'h00; endproperty
    property p_flags_wr;
        s_wr(ADDR_PROCESSOR_FLAGS) |=> {flags[7:1], 1'b0} == ($past(sfr_wdata) & 8'hfe);
    endproperty
    property p_pwr_wr; s_wr(ADDR_POWER_CONTROL) |=> power == ($past(sfr_wdata) & 8'hef); endproperty
    property p_pwr_bit;
        (bit_set || bit_clr) && !sfr_wr && sfr_addr == ADDR_POWER_CONTROL |=> $stable(power);
    endproperty
    property p_bitset;
        bit_set && !sfr_wr && sfr_addr == ADDR_PROCESSOR_FLAGS && bit_pos != 3'h0 |=> flags[$past(bit_pos)];
    endproperty
    property p_parity; !$past(rst) |-> flags.parity == ^$past(acc_value); endproperty
    property p_cal; $past(rst) |=> cal_coeff == $past(cal_factory); endproperty
    property p_rate;
        s_rd(ADDR_SPI_CTRL) ##0 spi_master_sel |=> sfr_rdata[0] == $past(spi_rate_bit0);
    endproperty
    a_rvalid: assert property (p_rvalid) else $error("no read answer");
    a_rev: assert property (p_rev) else $error("revision byte wrong");
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    a_flags_wr: assert property (p_flags_wr) else $error("flags write lost");
    a_pwr_wr: assert property (p_pwr_wr) else $error("power write wrong");
    a_pwr_bit: assert property (p_pwr_bit) else $error("power took bit op");
    a_bitset: assert property (p_bitset) else $error("flag bit set lost");
    a_parity: assert property (p_parity) else $error("parity wrong");
    a_cal: assert property (p_cal) else $error("calibration not loaded");
    a_rate: assert property (p_rate) else $error("rate bit wrong");
endmodule
`default_nettype wire

// ===== dv/csp_sfr_bank_tb.sv
// Purpose: Directed bench for the register bank
// Assumes: Core model drives the register bus
// Notes: Working registers and the ALU strobe are driven here as well
`timescale 1ns/1ps
`default_nettype none
module csp_sfr_bank_tb;
    import csp_pkg::*;
    localparam logic [7:0] SILICON_REV = 8'h3c; // Arbitrary value
    logic clk, rst, ss_pin, sfr_wr, sfr_rd, bit_set, bit_clr, sfr_rvalid, spi_master_sel, spi_rate_bit0;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, acc_value, p1_pin_in, wreg_wdata, wreg_rdata;
    logic [2:0] bit_pos, wreg_num;
    logic alu_we, wreg_we;
    logic [1:0] p1_pin_out, p1_pin_oe;
    csp_alu_t alu_flags;
    csp_cal_t cal_factory, cal_coeff;
    csp_flags_t flags;
    csp_power_t power;
    int err_total, num_checks;
    csp_sfr_bank #(.SILICON_REV(SILICON_REV)) DUT (.clk, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
        .bit_set, .bit_clr, .bit_pos, .sfr_rdata, .sfr_rvalid, .alu_we, .alu_flags, .acc_value,
        .wreg_num, .wreg_we, .wreg_wdata, .wreg_rdata, .cal_factory, .cal_coeff,
        .flags, .power, .spi_master_sel, .spi_rate_bit0, .ss_pin, .p1_pin_in, .p1_pin_out, .p1_pin_oe);
    csp_core_model u_core (.clk, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .bit_set, .bit_clr, .bit_pos,
        .sfr_rdata);
    task automatic chk(input logic [7:0] s, e);
        num_checks++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, s, e);
        end
    endtask
    task automatic rc(input logic [7:0] a, e);
        logic [7:0] d;
        u_core.rd(a, d);
        chk(d, e);
    endtask
    // Working register write in the bank the flags select now
    task automatic wr_w(input logic [2:0] n, input logic [7:0] d);
        @(negedge clk);
        wreg_num = n;
        wreg_wdata = d;
        wreg_we = 1'b1;
        @(negedge clk);
        wreg_we = 1'b0;
    endtask
    // Read data is registered, so look one cycle after the index
    task automatic rw(input logic [2:0] n, input logic [7:0] e);
        @(negedge clk);
        wreg_num = n;
        @(negedge clk);
        chk(wreg_rdata, e);
    endtask
    task automatic close_out();
        if (err_total == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Whole sequence needs well under 200 cycles
    initial begin
        #50us;
        err_total++;
        close_out();
    end
    initial begin
        {rst, ss_pin, acc_value, p1_pin_in} = {2'b11, 8'h00, 8'h3c};
        cal_factory = 32'h11223344;
        err_total = 0;
        num_checks = 0;
        {alu_we, alu_flags, wreg_we, wreg_num, wreg_wdata} = 16'h0;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        repeat (8) @(negedge clk);
        rc(8'h87, 8'h00);
        rc(ADDR_PROCESSOR_FLAGS, 8'h00);
        rc(ADDR_SILICON_REV, SILICON_REV);
        rc(8'hf1, 8'h11);
        rc(8'hf4, 8'h44);
        rc(ADDR_SPI_CTRL, 8'h05);
        rc(ADDR_PORT1, 8'h3c);
        u_core.op(ADDR_PORT1, 8'hfe, 4'h8, 3'h0);
        chk({6'h00, p1_pin_oe}, 8'h01);
        chk({6'h00, p1_pin_out}, 8'h00);
        u_core.op(ADDR_PORT1, 8'h00, 4'h2, 3'h0);
        chk({6'h00, p1_pin_oe}, 8'h00);
        wr_w(3'h5, 8'h05);
        u_core.op(8'hd0, 8'h18, 4'h8, 3'h0);
        rc(8'hd0, 8'h18);
        chk({6'h00, flags.bank_sel_hi, flags.bank_sel_lo}, 8'h03);
        wr_w(3'h5, 8'h35);
        rw(3'h5, 8'h35);
        u_core.op(8'hd0, 8'h00, 4'h2, 3'h7);
        rc(8'hd0, 8'h98);
        u_core.op(8'hd0, 8'h00, 4'h1, 3'h4);
        rc(8'hd0, 8'h88);
        wr_w(3'h5, 8'h15);
        rw(3'h5, 8'h15);
        u_core.op(8'h87, 8'h00, 4'h2, 3'h7);
        rc(8'h87, 8'h00);
        u_core.op(8'h87, 8'hff, 4'h8, 3'h0);
        rc(8'h87, 8'hef);
        chk(power, 8'hef);
        u_core.op(8'h91, 8'haa, 4'h8, 3'h0);
        rc(8'h91, 8'h00);
        u_core.op(ADDR_SILICON_REV, 8'h00, 4'h8, 3'h0);
        rc(ADDR_SILICON_REV, SILICON_REV);
        u_core.op(8'hf1, 8'ha5, 4'h8, 3'h0);
        rc(8'hf1, 8'ha5);
        acc_value = 8'h07;
        rc(8'hd0, 8'h89);
        @(negedge clk);
        {alu_we, alu_flags} = 4'hb;
        @(negedge clk);
        alu_we = 1'b0;
        rc(8'hd0, 8'h4d);
        ss_pin = 1'b0;
        repeat (6) @(negedge clk);
        rc(ADDR_SPI_CTRL, 8'h04);
        ss_pin = 1'b1;
        u_core.op(ADDR_SPI_CTRL, 8'h10, 4'h8, 3'h0);
        repeat (6) @(negedge clk);
        rc(ADDR_SPI_CTRL, 8'h10);
        u_core.op(8'hd0, 8'h00, 4'h8, 3'h0);
        rw(3'h5, 8'h05);
        close_out();
    end
endmodule
bind csp_sfr_bank csp_sfr_bank_assertions #(.SILICON_REV(SILICON_REV)) u_chk (.clk, .rst, .sfr_addr,
    .sfr_wr, .sfr_rd, .sfr_wdata, .bit_set, .bit_clr, .bit_pos, .sfr_rdata, .sfr_rvalid, .acc_value,
    .cal_factory, .cal_coeff, .flags, .power, .spi_master_sel, .spi_rate_bit0);
`default_nettype wire

// ===== logic/csp_pkg.sv
// Purpose: Shared constants and types for the status/power register bank
// Assumes: 8-bit register bus from the processor core, one clock
// Notes: Addresses are register-space byte addresses
package csp_pkg;
    localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
    localparam logic [7:0] ADDR_PORT1 = 8'h90;
    localparam logic [7:0] ADDR_SILICON_REV = 8'hc2;
    localparam logic [7:0] ADDR_PROCESSOR_FLAGS = 8'hd0;
    localparam logic [7:0] ADDR_ADC_OFS_LO = 8'hf1;
    localparam logic [7:0] ADDR_ADC_OFS_HI = 8'hf2;
    localparam logic [7:0] ADDR_ADC_GAIN_LO = 8'hf3;
    localparam logic [7:0] ADDR_ADC_GAIN_HI = 8'hf4;
    localparam logic [7:0] ADDR_SPI_CTRL = 8'hf8;

    localparam logic [7:0] RST_POWER_CONTROL = 8'h00;
    localparam logic [7:0] RST_PROCESSOR_FLAGS = 8'h00;
    localparam logic [7:0] RST_PORT1 = 8'hff;
    localparam logic [7:0] RST_SPI_CTRL = 8'h04;
    localparam logic [7:0] RST_CAL = 8'h00;

    localparam int unsigned SPI_MASTER_SEL_POS = 4;
    localparam int unsigned SPI_RATE_BIT0_POS = 0;
    localparam int unsigned WREG_DEPTH = 32;
    localparam int unsigned BANK_SIZE = 8;
    localparam logic [1:0] P1_BIDIR_MASK = 2'b11;

    // Field order gives bit 7 first
    typedef struct packed {
        logic carry_flag;
        logic half_carry;
        logic user_flag_a;
        logic bank_sel_hi;
        logic bank_sel_lo;
        logic signed_wrap_flag;
        logic user_flag_b;
        logic parity;
    } csp_flags_t;

    typedef struct packed {
        logic baud_doubler;
        logic spi_wake_irq_en;
        logic ext0_wake_irq_en;
        logic reserved4;
        logic spare_flag_1;
        logic spare_flag_0;
        logic deep_sleep_en;
        logic doze_en;
    } csp_power_t;

    typedef struct packed {
        logic [7:0] ofs_lo;
        logic [7:0] ofs_hi;
        logic [7:0] gain_lo;
        logic [7:0] gain_hi;
    } csp_cal_t;

    typedef struct packed {
        logic carry_flag;
        logic half_carry;
        logic signed_wrap_flag;
    } csp_alu_t;
endpackage

// ===== logic/csp_sfr_bank.sv
// Purpose: Flags, power control and general register-space decode for the core
// Assumes: Core drives one access per cycle; pins are asynchronous
// Notes: Read data appear one cycle after the read strobe
//
// Summary of operation
// - Flags register sits at D0H, resets to 00H, bit-addressable.
// - Flag bits 4 and 3 pick working register bank 0 to 3.
// - Carry bit 7, half carry 6, overflow 2, parity 0, user 5 and 1.
// - Power control sits at 87H, resets to 00H, byte access only.
// - Power bit 1 deep sleep, bit 0 doze, bits 3,2 spare, bit 4 reserved.
// - Power bit 6 lets SPI wake, bit 5 lets external interrupt 0 wake.
// - Power bit 7 doubles the UART baud rate.
// - All registers except PC and working banks live in register space.
// - Unoccupied addresses store nothing; reads undefined, writes ignored. Here reads return 00H.
// - Addresses with low nibble 0H or 8H accept single-bit set/clear/test.
// - Port 1 pins 0,1 bidirectional; pins 2 to 7 input only.
// - Read-only byte returns the silicon revision identifier.
// - Converter calibration registers load factory values at power-on; writable later.
// - With SPI master-select clear, rate bit 0 reads the slave-select pin.
// - Lowest 32 RAM bytes form four banks of eight working registers.
`timescale 1ns/1ps
`default_nettype none
module csp_sfr_bank
    import csp_pkg::*;
#(
    parameter logic [7:0] SILICON_REV = 8'h5a // Arbitrary value
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic bit_set,
    input wire logic bit_clr,
    input wire logic [2:0] bit_pos,
    output logic [7:0] sfr_rdata,
    output logic sfr_rvalid,
    input wire logic alu_we,
    input wire csp_alu_t alu_flags,
    input wire logic [7:0] acc_value,
    input wire logic [2:0] wreg_num,
    input wire logic wreg_we,
    input wire logic [7:0] wreg_wdata,
    output logic [7:0] wreg_rdata,
    input wire csp_cal_t cal_factory,
    output csp_cal_t cal_coeff,
    output csp_flags_t flags,
    output csp_power_t power,
    output logic spi_master_sel,
    output logic spi_rate_bit0,
    input wire logic ss_pin,
    input wire logic [7:0] p1_pin_in,
    output logic [1:0] p1_pin_out,
    output logic [1:0] p1_pin_oe
);
    typedef enum logic {CSP_LOAD, CSP_RUN} csp_state_t;

    csp_state_t state, next_state;
    csp_flags_t next_flags;
    csp_power_t next_power;
    csp_cal_t next_cal;
    logic [7:0] spi_ctrl, next_spi_ctrl;
    logic [7:0] p1_latch, next_p1_latch;
    logic [7:0] next_rdata;
    logic [1:0] next_p1_oe;
    logic [8:0] sync1, sync2, sync3;
    logic [8:0] pin_level, next_pin_level;

    // Bit access only where the low three address bits are zero
    function automatic logic bit_addressable(input logic [7:0] a);
        return a[2:0] == 3'h0;
    endfunction

    function automatic logic [7:0] apply_write(input logic [7:0] cur, input logic [7:0] a,
                                               input logic wr, input logic [7:0] wd,
                                               input logic bs, input logic bc, input logic [2:0] bp);
        logic [7:0] v;
        v = cur;
        if (wr) begin
            v = wd;
        end else if (bit_addressable(a) && (bs || bc)) begin
            v[bp] = bs;
        end
        return v;
    endfunction

    // Three-stage pin capture; a level counts once stages two and three agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1 <= '1;
            sync2 <= '1;
            sync3 <= '1;
        end else begin
            sync1 <= {ss_pin, p1_pin_in};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    always_comb begin
        next_pin_level = pin_level;
        for (int i = 0; i < 9; i++) begin
            if (sync2[i] == sync3[i]) begin
                next_pin_level[i] = sync3[i];
            end
        end
    end

    always_comb begin
        next_state = CSP_RUN;
        next_flags = flags;
        next_power = power;
        next_cal = cal_coeff;
        next_spi_ctrl = spi_ctrl;
        next_p1_latch = p1_latch;
        next_rdata = 8'h00;
        if (alu_we) begin
            next_flags.carry_flag = alu_flags.carry_flag;
            next_flags.half_carry = alu_flags.half_carry;
            next_flags.signed_wrap_flag = alu_flags.signed_wrap_flag;
        end
        // Explicit register write overrides an ALU update in the same cycle
        if (sfr_addr == ADDR_PROCESSOR_FLAGS) begin
            next_flags = apply_write(next_flags, sfr_addr, sfr_wr, sfr_wdata, bit_set, bit_clr, bit_pos);
        end
        next_flags.parity = ^acc_value;
        if (sfr_addr == ADDR_POWER_CONTROL && sfr_wr) begin
            next_power = sfr_wdata;
            next_power.reserved4 = 1'b0;
        end
        if (sfr_addr == ADDR_SPI_CTRL) begin
            next_spi_ctrl = apply_write(spi_ctrl, sfr_addr, sfr_wr, sfr_wdata, bit_set, bit_clr, bit_pos);
        end
        if (sfr_addr == ADDR_PORT1) begin
            next_p1_latch = apply_write(p1_latch, sfr_addr, sfr_wr, sfr_wdata, bit_set, bit_clr, bit_pos);
        end
        if (sfr_wr) begin
            case (sfr_addr)
                ADDR_ADC_OFS_LO: next_cal.ofs_lo = sfr_wdata;
                ADDR_ADC_OFS_HI: next_cal.ofs_hi = sfr_wdata;
                ADDR_ADC_GAIN_LO: next_cal.gain_lo = sfr_wdata;
                ADDR_ADC_GAIN_HI: next_cal.gain_hi = sfr_wdata;
                default: ;
            endcase
        end
        // Factory load in the first cycle after reset release
        if (state == CSP_LOAD) begin
            next_cal = cal_factory;
        end
        if (sfr_rd) begin
            case (sfr_addr)
                ADDR_PROCESSOR_FLAGS: next_rdata = flags;
                ADDR_POWER_CONTROL: next_rdata = power;
                ADDR_SILICON_REV: next_rdata = SILICON_REV;
                ADDR_ADC_OFS_LO: next_rdata = cal_coeff.ofs_lo;
                ADDR_ADC_OFS_HI: next_rdata = cal_coeff.ofs_hi;
                ADDR_ADC_GAIN_LO: next_rdata = cal_coeff.gain_lo;
                ADDR_ADC_GAIN_HI: next_rdata = cal_coeff.gain_hi;
                ADDR_PORT1: next_rdata = pin_level[7:0];
                ADDR_SPI_CTRL: begin
                    next_rdata = spi_ctrl;
                    if (!spi_ctrl[SPI_MASTER_SEL_POS]) begin
                        next_rdata[SPI_RATE_BIT0_POS] = pin_level[8];
                    end
                end
                // Unoccupied or reserved: no storage, reads as zero
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // Only pins 0 and 1 can drive; they pull low when their latch bit is zero
    always_comb begin
        next_p1_oe = ~next_p1_latch[1:0] & P1_BIDIR_MASK;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= CSP_LOAD;
            flags <= RST_PROCESSOR_FLAGS;
            power <= RST_POWER_CONTROL;
            cal_coeff <= {4{RST_CAL}};
            spi_ctrl <= RST_SPI_CTRL;
            p1_latch <= RST_PORT1;
            sfr_rdata <= 8'h00;
            sfr_rvalid <= 1'b0;
            pin_level <= '1;
            p1_pin_oe <= 2'b00;
            p1_pin_out <= 2'b00;
            spi_master_sel <= 1'b0;
            spi_rate_bit0 <= 1'b0;
        end else begin
            state <= next_state;
            flags <= next_flags;
            power <= next_power;
            cal_coeff <= next_cal;
            spi_ctrl <= next_spi_ctrl;
            p1_latch <= next_p1_latch;
            sfr_rdata <= next_rdata;
            sfr_rvalid <= sfr_rd;
            pin_level <= next_pin_level;
            p1_pin_oe <= next_p1_oe;
            p1_pin_out <= 2'b00;
            spi_master_sel <= next_spi_ctrl[SPI_MASTER_SEL_POS];
            spi_rate_bit0 <= next_spi_ctrl[SPI_RATE_BIT0_POS];
        end
    end

    // Bank from the live flags, so a bank switch takes effect next cycle
    csp_wreg_ram u_wreg (
        .clk(clk),
        .addr({flags.bank_sel_hi, flags.bank_sel_lo, wreg_num}),
        .we(wreg_we),
        .wdata(wreg_wdata),
        .rdata(wreg_rdata)
    );
    // Power bits reach sleep, wake and baud logic straight from the register
endmodule
`default_nettype wire

// ===== logic/csp_wreg_ram.sv
// Purpose: Working register storage, four banks of eight bytes
// Assumes: Single port, write and registered read share the index
// Notes: Contents are not cleared by reset
`timescale 1ns/1ps
`default_nettype none
module csp_wreg_ram
    import csp_pkg::*;
(
    input wire logic clk,
    input wire logic [4:0] addr,
    input wire logic we,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem [WREG_DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule
`default_nettype wire
